// ==== hdl/acu_top.sv ====
// Contract
// - command word: flags, opcode high; status low
// - link in dword two, parameters follow
// - decode eight three-bit opcodes
// - no_operation only fetches, decodes, completes
// - unique address load takes station address
// - multicast load accepts addresses from parameters
// - default parameters after reset until configure
// - dump writes internal registers to memory
// - start, resume or chaining begins; receive delays (here rx_busy holds off only start and resume, not chaining)
// - fetch four dwords in one burst
// - read and store link before action
// - prefetch next command word, keep fields
// - completion while unit still active
// - write status with done and success
// - transmit done at end of buffer dma
// - wire outcome goes to statistics counters
// - notify flag raises block done request
// - last goes idle, suspend suspends, else chain
// - suspend reports left-active only if configured
// - finally update system control block status
// - device sets done; success zero means error
// - last block always reports left-active
// - next address is base plus link
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
module acu_top
	import acu_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// memory master
	output logic             mem_req,
	output logic             mem_we,
	output logic             mem_burst,
	output logic [31:0]      mem_addr,
	output logic [31:0]      mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [31:0] mem_rdata,
	// receive unit
	input  wire logic        rx_busy,
	// transmit path
	output logic             tx_go,
	input  wire logic        tx_dma_done,
	input  wire logic        tx_dma_ok,
	input  wire logic        tx_wire_done,
	input  wire logic        tx_wire_ok,
	// self-test
	output logic             diag_go,
	input  wire logic        diag_done,
	input  wire logic        diag_pass,
	// events and loaded state
	output logic             block_done_interrupt,
	output logic             unit_left_active_interrupt,
	output logic [47:0]      station_addr,
	output logic [31:0]      mcast_addr,
	output logic [31:0]      cfg_word
);

	typedef struct packed {
		acu_state_t  st;
		logic [31:0] base;
		logic [31:0] ptr;
		logic [31:0] cur;
		logic [31:0] w0;
		logic [31:0] link;
		logic [31:0] w2;
		logic [31:0] w3;
		logic [1:0]  widx;
		logic [2:0]  didx;
		logic [5:0]  nxt_fields;
		logic        ok;
		logic [47:0] ia;
		logic [31:0] cfg;
		logic [31:0] mc;
		logic [31:0] txg;
		logic [31:0] txb;
		logic [1:0]  unit;
		logic        cx_st;
		logic        cna_st;
		logic        start_pend;
		logic        resume_pend;
		logic        mreq;
		logic        mwe;
		logic        mburst;
		logic [31:0] maddr;
		logic [31:0] mwdata;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        txgo;
		logic        diaggo;
		logic        cxr;
		logic        cnar;
	} acu_regs_t;

	acu_regs_t s_ff;
	acu_regs_t nxt_s;

	logic        apb_done;
	logic        apb_wr;
	logic        cx_clr;
	logic        cna_clr;
	logic        cx_set;
	logic        cna_set;
	logic [31:0] dump_word;
	acu_op_t     op;

	// the transfer completes on the edge where our own pready is high
	assign apb_done = psel & penable & s_ff.pready;
	assign apb_wr   = apb_done & pwrite;
	// reserved bits 28:19 take no part in decoding
	assign op       = acu_op_t'(s_ff.w0[CW_OP_HI:CW_OP_LO]);

	// words written by a dump, in index order
	always_comb begin
		unique case (s_ff.didx)
			3'h0:    dump_word = s_ff.ia[31:0];
			3'h1:    dump_word = {16'h0000, s_ff.ia[47:32]};
			3'h2:    dump_word = s_ff.cfg;
			3'h3:    dump_word = s_ff.mc;
			3'h4:    dump_word = s_ff.txg;
			3'h5:    dump_word = s_ff.txb;
			default: dump_word = 32'h0000_0000;
		endcase
	end

	// all next-state logic of the unit
	always_comb begin
		nxt_s        = s_ff;
		cx_set       = 1'b0;
		cna_set      = 1'b0;
		nxt_s.txgo   = 1'b0;
		nxt_s.diaggo = 1'b0;
		nxt_s.cxr    = 1'b0;
		nxt_s.cnar   = 1'b0;
		cx_clr  = apb_wr && paddr == OFS_STAT && pwdata[STAT_CX];
		cna_clr = apb_wr && paddr == OFS_STAT && pwdata[STAT_CNA];

		// apb: one wait state, registered read data
		nxt_s.pready  = psel & penable & ~s_ff.pready;
		nxt_s.pslverr = 1'b0;
		if (psel & penable & ~s_ff.pready) begin
			unique case (paddr)
				OFS_CTRL:   nxt_s.prdata = 32'h0000_0000;
				OFS_PTR:    nxt_s.prdata = s_ff.ptr;
				OFS_BASE:   nxt_s.prdata = s_ff.base;
				OFS_STAT: begin
					nxt_s.prdata = 32'h0000_0000;
					nxt_s.prdata[STAT_UNIT_HI:STAT_UNIT_LO] = s_ff.unit;
					nxt_s.prdata[STAT_CX]  = s_ff.cx_st;
					nxt_s.prdata[STAT_CNA] = s_ff.cna_st;
				end
				OFS_TXGOOD: nxt_s.prdata = s_ff.txg;
				OFS_TXBAD:  nxt_s.prdata = s_ff.txb;
				OFS_IALO:   nxt_s.prdata = s_ff.ia[31:0];
				OFS_IAHI:   nxt_s.prdata = {16'h0000, s_ff.ia[47:32]};
				OFS_CFG:    nxt_s.prdata = s_ff.cfg;
				OFS_NEXT:   nxt_s.prdata = {26'h0, s_ff.nxt_fields};
				default: begin
					nxt_s.prdata  = 32'h0000_0000;
					nxt_s.pslverr = 1'b1;
				end
			endcase
		end
		if (apb_wr && paddr == OFS_PTR) begin
			nxt_s.ptr = pwdata;
		end
		if (apb_wr && paddr == OFS_BASE) begin
			nxt_s.base = pwdata;
		end
		// a control command waits here while the receive unit is busy
		if (apb_wr && paddr == OFS_CTRL && pwdata[CTRL_START]) begin
			nxt_s.start_pend = 1'b1;
		end
		if (apb_wr && paddr == OFS_CTRL && pwdata[CTRL_RESUME]) begin
			nxt_s.resume_pend = 1'b1;
		end

		// wire outcome is counted, never written to the block
		if (tx_wire_done) begin
			if (tx_wire_ok) begin
				nxt_s.txg = s_ff.txg + 32'h0000_0001;
			end else begin
				nxt_s.txb = s_ff.txb + 32'h0000_0001;
			end
		end

		unique case (s_ff.st)
			ST_IDLE, ST_SUSP: begin
				nxt_s.resume_pend = (s_ff.st == ST_IDLE) ? 1'b0 : nxt_s.resume_pend;
				if (!rx_busy && s_ff.start_pend) begin
					nxt_s.start_pend  = 1'b0;
					nxt_s.resume_pend = 1'b0;
					nxt_s.cur   = s_ff.base + s_ff.ptr;
					nxt_s.st    = ST_FETCH;
					nxt_s.unit  = UNIT_ACTIVE;
					nxt_s.widx  = 2'h0;
					nxt_s.mreq  = 1'b1;
					nxt_s.mwe   = 1'b0;
					nxt_s.mburst = 1'b1;
					nxt_s.maddr = s_ff.base + s_ff.ptr;
				end else if (!rx_busy && s_ff.resume_pend && s_ff.st == ST_SUSP) begin
					nxt_s.resume_pend = 1'b0;
					nxt_s.cur   = s_ff.base + s_ff.link;
					nxt_s.st    = ST_FETCH;
					nxt_s.unit  = UNIT_ACTIVE;
					nxt_s.widx  = 2'h0;
					nxt_s.mreq  = 1'b1;
					nxt_s.mwe   = 1'b0;
					nxt_s.mburst = 1'b1;
					nxt_s.maddr = s_ff.base + s_ff.link;
				end
			end
			ST_FETCH: begin
				// four words under one held burst request
				if (mem_ack) begin
					unique case (s_ff.widx)
						2'h0: nxt_s.w0   = mem_rdata;
						2'h1: nxt_s.link = mem_rdata;
						2'h2: nxt_s.w2   = mem_rdata;
						2'h3: nxt_s.w3   = mem_rdata;
					endcase
					nxt_s.widx  = s_ff.widx + 2'h1;
					nxt_s.maddr = s_ff.maddr + DW_BYTES;
					if (s_ff.widx == FETCH_LAST) begin
						nxt_s.mburst = 1'b0;
						if (s_ff.w0[CW_LAST]) begin
							nxt_s.mreq = 1'b0;
							nxt_s.st   = ST_EXEC;
						end else begin
							nxt_s.maddr = s_ff.base + s_ff.link;
							nxt_s.st    = ST_PREF;
						end
					end
				end
			end
			ST_PREF: begin
				// only the flags and opcode of the next block are kept
				if (mem_ack) begin
					nxt_s.mreq = 1'b0;
					nxt_s.nxt_fields = {mem_rdata[CW_LAST], mem_rdata[CW_SUSP],
						mem_rdata[CW_NOTIFY], mem_rdata[CW_OP_HI:CW_OP_LO]};
					nxt_s.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				nxt_s.ok = 1'b1;
				nxt_s.st = ST_WSTAT;
				unique case (op)
					OP_NOP, OP_UCODE: begin
					end
					OP_IA:  nxt_s.ia  = {s_ff.w3[15:0], s_ff.w2};
					OP_CFG: nxt_s.cfg = s_ff.w2;
					OP_MC:  nxt_s.mc  = s_ff.w3;
					OP_TX: begin
						nxt_s.txgo = 1'b1;
						nxt_s.st   = ST_TXW;
					end
					OP_DUMP: begin
						nxt_s.didx = 3'h0;
						nxt_s.st   = ST_DUMP;
					end
					OP_DIAG: begin
						nxt_s.diaggo = 1'b1;
						nxt_s.st     = ST_DIAGW;
					end
				endcase
				if (nxt_s.st == ST_WSTAT) begin
					nxt_s.mreq   = 1'b1;
					nxt_s.mwe    = 1'b1;
					nxt_s.maddr  = s_ff.cur;
					nxt_s.mwdata = {s_ff.w0[31:16], 1'b1, 1'b0, 1'b1, 13'h0000};
				end
			end
			ST_TXW: begin
				// done is written once buffer dma ends, not the wire
				if (tx_dma_done) begin
					nxt_s.ok     = tx_dma_ok;
					nxt_s.st     = ST_WSTAT;
					nxt_s.mreq   = 1'b1;
					nxt_s.mwe    = 1'b1;
					nxt_s.maddr  = s_ff.cur;
					nxt_s.mwdata = {s_ff.w0[31:16], 1'b1, 1'b0, tx_dma_ok, 13'h0000};
				end
			end
			ST_DIAGW: begin
				if (diag_done) begin
					nxt_s.ok     = diag_pass;
					nxt_s.st     = ST_WSTAT;
					nxt_s.mreq   = 1'b1;
					nxt_s.mwe    = 1'b1;
					nxt_s.maddr  = s_ff.cur;
					nxt_s.mwdata = {s_ff.w0[31:16], 1'b1, 1'b0, diag_pass, 13'h0000};
				end
			end
			ST_DUMP: begin
				// target address is the first parameter dword
				nxt_s.mreq   = 1'b1;
				nxt_s.mwe    = 1'b1;
				nxt_s.maddr  = s_ff.w2 + {27'h0, s_ff.didx, 2'b00};
				nxt_s.mwdata = dump_word;
				if (s_ff.mreq && mem_ack) begin
					if (s_ff.didx == DUMP_LAST) begin
						nxt_s.st     = ST_WSTAT;
						nxt_s.maddr  = s_ff.cur;
						nxt_s.mwdata = {s_ff.w0[31:16], 1'b1, 1'b0, 1'b1, 13'h0000};
					end else begin
						nxt_s.didx   = s_ff.didx + 3'h1;
						nxt_s.mreq   = 1'b0;
					end
				end
			end
			ST_WSTAT: begin
				// done set, success as found, unit still active
				if (mem_ack) begin
					nxt_s.mreq = 1'b0;
					nxt_s.mwe  = 1'b0;
					nxt_s.st   = ST_FIN;
				end
			end
			ST_FIN: begin
				if (s_ff.w0[CW_NOTIFY]) begin
					nxt_s.cxr = 1'b1;
					cx_set    = 1'b1;
				end
				if (s_ff.w0[CW_LAST]) begin
					nxt_s.st   = ST_IDLE;
					nxt_s.unit = UNIT_IDLE;
					nxt_s.cnar = 1'b1;
					cna_set    = 1'b1;
				end else if (s_ff.w0[CW_SUSP]) begin
					nxt_s.st   = ST_SUSP;
					nxt_s.unit = UNIT_SUSP;
					if (s_ff.cfg[CFG_CNA_EN]) begin
						nxt_s.cnar = 1'b1;
						cna_set    = 1'b1;
					end
				end else begin
					nxt_s.cur    = s_ff.base + s_ff.link;
					nxt_s.maddr  = s_ff.base + s_ff.link;
					nxt_s.st     = ST_FETCH;
					nxt_s.widx   = 2'h0;
					nxt_s.mreq   = 1'b1;
					nxt_s.mburst = 1'b1;
				end
			end
			default: nxt_s.st = ST_IDLE;
		endcase

		// sticky status: a set in the clearing cycle wins
		nxt_s.cx_st  = cx_set | (s_ff.cx_st & ~cx_clr);
		nxt_s.cna_st = cna_set | (s_ff.cna_st & ~cna_clr);
	end

	// single state register, constants only under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff     <= '0;
			s_ff.st  <= ST_IDLE;
			s_ff.ia  <= IA_RESET;
			s_ff.cfg <= CFG_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// every output is a field of the state register
	assign pready                     = s_ff.pready;
	assign pslverr                    = s_ff.pslverr;
	assign prdata                     = s_ff.prdata;
	assign mem_req                    = s_ff.mreq;
	assign mem_we                     = s_ff.mwe;
	assign mem_burst                  = s_ff.mburst;
	assign mem_addr                   = s_ff.maddr;
	assign mem_wdata                  = s_ff.mwdata;
	assign tx_go                      = s_ff.txgo;
	assign diag_go                    = s_ff.diaggo;
	assign block_done_interrupt       = s_ff.cxr;
	assign unit_left_active_interrupt = s_ff.cnar;
	assign station_addr               = s_ff.ia;
	assign mcast_addr                 = s_ff.mc;
	assign cfg_word                   = s_ff.cfg;

endmodule : acu_top

// ==== hdl/acu_pkg.sv ====
package acu_pkg;
	// register byte offsets on the apb side
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PTR    = 8'h04;
	localparam logic [7:0] OFS_BASE   = 8'h08;
	localparam logic [7:0] OFS_STAT   = 8'h0c;
	localparam logic [7:0] OFS_TXGOOD = 8'h10;
	localparam logic [7:0] OFS_TXBAD  = 8'h14;
	localparam logic [7:0] OFS_IALO   = 8'h18;
	localparam logic [7:0] OFS_IAHI   = 8'h1c;
	localparam logic [7:0] OFS_CFG    = 8'h20;
	localparam logic [7:0] OFS_NEXT   = 8'h24;
	// control register bits
	localparam int CTRL_START  = 0;
	localparam int CTRL_RESUME = 1;
	// status register fields
	localparam int STAT_UNIT_LO = 0;
	localparam int STAT_UNIT_HI = 1;
	localparam int STAT_CX      = 8;
	localparam int STAT_CNA     = 9;
	// command word fields
	localparam int CW_LAST   = 31;
	localparam int CW_SUSP   = 30;
	localparam int CW_NOTIFY = 29;
	localparam int CW_OP_HI  = 18;
	localparam int CW_OP_LO  = 16;
	localparam int CW_DONE   = 15;
	localparam int CW_OK     = 13;
	// configuration word bit that enables the left-active report on suspend
	localparam int CFG_CNA_EN = 0;
	// reset values
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [47:0] IA_RESET  = 48'hffff_ffff_ffff;
	// block layout
	localparam logic [31:0] DW_BYTES   = 32'h0000_0004;
	localparam logic [1:0]  FETCH_LAST = 2'h3;
	localparam logic [2:0]  DUMP_LAST  = 3'h5;
	// unit state codes reported in the status register
	localparam logic [1:0] UNIT_IDLE   = 2'h0;
	localparam logic [1:0] UNIT_SUSP   = 2'h1;
	localparam logic [1:0] UNIT_ACTIVE = 2'h2;

	typedef enum logic [2:0] {
		OP_NOP   = 3'b000,
		OP_IA    = 3'b001,
		OP_CFG   = 3'b010,
		OP_MC    = 3'b011,
		OP_TX    = 3'b100,
		OP_UCODE = 3'b101,
		OP_DUMP  = 3'b110,
		OP_DIAG  = 3'b111
	} acu_op_t;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0000,
		ST_SUSP  = 4'b0001,
		ST_FETCH = 4'b0010,
		ST_PREF  = 4'b0011,
		ST_EXEC  = 4'b0100,
		ST_TXW   = 4'b0101,
		ST_DIAGW = 4'b0110,
		ST_DUMP  = 4'b0111,
		ST_WSTAT = 4'b1000,
		ST_FIN   = 4'b1001
	} acu_state_t;
endpackage : acu_pkg

// ==== dv/acu_props.sv ====
`timescale 1ns/1ps
module acu_props (
	// apb side
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	// memory side
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic        mem_burst,
	input wire logic [31:0] mem_addr,
	input wire logic        mem_ack,
	// events
	input wire logic        tx_dma_done,
	input wire logic        block_done_interrupt,
	input wire logic        unit_left_active_interrupt
);
	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a write accepted by memory; status write-back is the last of these
	wire logic st_ack = mem_req && mem_we && mem_ack;
	property p_ready_wait; $rose(psel && penable) |-> !pready ##1 pready; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready wait wrong");
	property p_ready_acc; pready |-> psel && penable; endproperty
	a_ready_acc: assert property (p_ready_acc) else $error("pready outside access");
	property p_err; pslverr |-> pready; endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	// burst words follow each other at consecutive addresses
	property p_burst;
		(mem_req && mem_ack && mem_burst && !mem_we) ##1 (mem_req && mem_burst) |-> mem_addr == $past(mem_addr) + 32'h4;
	endproperty
	a_burst: assert property (p_burst) else $error("burst address not consecutive");
	property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we); endproperty
	a_hold: assert property (p_hold) else $error("memory request dropped");
	property p_tx; tx_dma_done |-> ##[1:6] (mem_req && mem_we); endproperty
	a_tx: assert property (p_tx) else $error("no status write after dma");
	property p_bd; block_done_interrupt |-> $past(st_ack) || $past(st_ack, 2); endproperty
	a_bd: assert property (p_bd) else $error("block done not after status");
	property p_la;
		unit_left_active_interrupt |-> ($past(st_ack) || $past(st_ack, 2)) ##1 !unit_left_active_interrupt;
	endproperty
	a_la: assert property (p_la) else $error("left active badly placed");
	c_bd: cover property (block_done_interrupt);
	c_la: cover property (unit_left_active_interrupt);
	c_err: cover property (pslverr);
endmodule : acu_props
bind acu_top acu_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_burst(mem_burst), .mem_addr(mem_addr),
	.mem_ack(mem_ack), .tx_dma_done(tx_dma_done), .block_done_interrupt(block_done_interrupt),
	.unit_left_active_interrupt(unit_left_active_interrupt));

// ==== dv/acu_host_mem.sv ====
`timescale 1ns/1ps
module acu_host_mem (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// requests and stall setting
	input wire logic        mem_req,
	input wire logic        mem_we,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	input wire logic [3:0]  stall,
	// answers
	output logic            mem_ack,
	output logic [31:0]     mem_rdata
);
	logic [31:0] mem [0:255];
	logic [3:0]  wait_cnt;
	// read data is good only with ack; it toggles otherwise so stale use shows
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack <= 1'b0;
			mem_rdata <= 32'h0000_0000;
			wait_cnt <= 4'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req && !mem_ack && wait_cnt < stall) begin
				wait_cnt <= wait_cnt + 4'h1;
			end else if (mem_req && !mem_ack) begin
				wait_cnt <= 4'h0;
				mem_ack <= 1'b1;
				if (mem_we) mem[mem_addr[9:2]] <= mem_wdata;
				else mem_rdata <= mem[mem_addr[9:2]];
			end
		end
	end
endmodule : acu_host_mem

// ==== dv/tb_action_command_unit.sv ====
`timescale 1ns/1ps
module tb_action_command_unit;
	import acu_pkg::*;
	// driven inputs
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic rx_busy = 1'b0, tx_dma_done = 1'b0, tx_dma_ok = 1'b0, tx_wire_done = 1'b0, tx_wire_ok = 1'b0;
	logic diag_done = 1'b0, diag_pass = 1'b1;
	logic [3:0] stall = 4'h0;
	// observed outputs
	logic pready, pslverr, mem_req, mem_we, mem_burst, mem_ack, tx_go, diag_go, bdi, lai, e;
	logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, mcast_addr, cfg_word, q;
	logic [47:0] station_addr;
	logic [31:0] w0s [8];
	logic [31:0] dmp [6];
	int num_errors = 0, n_checks = 0, n_bd = 0, n_la = 0;

	acu_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .mem_req(mem_req), .mem_we(mem_we),
		.mem_burst(mem_burst), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .rx_busy(rx_busy), .tx_go(tx_go), .tx_dma_done(tx_dma_done), .tx_dma_ok(tx_dma_ok),
		.tx_wire_done(tx_wire_done), .tx_wire_ok(tx_wire_ok), .diag_go(diag_go), .diag_done(diag_done),
		.diag_pass(diag_pass), .block_done_interrupt(bdi), .unit_left_active_interrupt(lai),
		.station_addr(station_addr), .mcast_addr(mcast_addr), .cfg_word(cfg_word));
	acu_host_mem mem_i (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .stall(stall), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	always #12.5 pclk = ~pclk;
	// dma and self-test answer at once; event pulses are counted
	always @(posedge pclk) begin
		tx_dma_done <= tx_go;
		diag_done <= diag_go;
		n_bd <= n_bd + int'(bdi === 1'b1);
		n_la <= n_la + int'(lai === 1'b1);
	end

	function automatic logic [31:0] cw(input logic [2:0] f, input acu_op_t op);
		return {f, 10'h000, op, 16'h0000};
	endfunction : cw
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask : rdc
	task automatic waitu(input logic [1:0] u);
		for (int i = 0; i < 400; i++) begin
			apb(1'b0, OFS_STAT, 32'h0);
			if (q[1:0] === u) break;
		end
		chk(q[1:0], u);
	endtask : waitu
	task automatic results();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : results

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		chk(station_addr, 48'hffff_ffff_ffff);
		chk(cfg_word, CFG_RESET);
		rdc(OFS_STAT, 32'h0);
		apb(1'b0, 8'h28, 32'h0);
		chk({e, q}, 33'h1_0000_0000);
		// one good and one bad frame on the wire
		for (int i = 0; i < 2; i++) begin
			@(posedge pclk);
			tx_wire_done <= 1'b1;
			tx_wire_ok <= (i == 0);
			@(posedge pclk);
			tx_wire_done <= 1'b0;
		end
		rdc(OFS_TXGOOD, 32'h1);
		rdc(OFS_TXBAD, 32'h1);
		// chain of eight blocks at base 100h, every opcode once, reserved bits set in one
		w0s = '{cw(3'b001, OP_IA), cw(3'b000, OP_CFG) | 32'h1ff8_0000, cw(3'b000, OP_MC), cw(3'b010, OP_NOP),
			cw(3'b001, OP_TX), cw(3'b000, OP_DIAG), cw(3'b000, OP_UCODE), cw(3'b100, OP_DUMP)};
		for (int i = 0; i < 8; i++) begin
			mem_i.mem[64 + 4 * i] = w0s[i];
			mem_i.mem[65 + 4 * i] = 32'(16 * (i + 1));
		end
		mem_i.mem[66] = 32'h4433_2211;
		mem_i.mem[67] = 32'h0000_6655;
		mem_i.mem[70] = 32'h0000_0a00;
		mem_i.mem[75] = 32'h0100_5e01;
		mem_i.mem[94] = 32'h0000_0300;
		apb(1'b1, OFS_BASE, 32'h100);
		apb(1'b1, OFS_PTR, 32'h0);
		apb(1'b1, OFS_CTRL, 32'h1);
		waitu(UNIT_SUSP);
		chk(station_addr, 48'h6655_4433_2211);
		chk(cfg_word, 32'h0000_0a00);
		chk(mcast_addr, 32'h0100_5e01);
		rdc(OFS_STAT, 32'h101);
		rdc(OFS_NEXT, 32'h00c);
		chk(n_la, 0);
		apb(1'b1, OFS_STAT, 32'h300);
		rdc(OFS_STAT, 32'h1);
		// slow memory; resume held off while receive is busy
		stall <= 4'h3;
		rx_busy <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h2);
		repeat (8) @(posedge pclk);
		chk(mem_req, 1'b0);
		rx_busy <= 1'b0;
		waitu(UNIT_IDLE);
		rdc(OFS_STAT, 32'h300);
		for (int i = 0; i < 8; i++) chk(mem_i.mem[64 + 4 * i], {w0s[i][31:16], (i == 4) ? 16'h8000 : 16'ha000});
		dmp = '{32'h4433_2211, 32'h6655, 32'h0a00, 32'h0100_5e01, 32'h1, 32'h1};
		for (int i = 0; i < 6; i++) chk(mem_i.mem[192 + i], dmp[i]);
		chk(n_bd, 2);
		chk(n_la, 1);
		// suspend after a configure that turns the left-active report on; the report follows the new word
		mem_i.mem[96] = cw(3'b010, OP_CFG);
		mem_i.mem[97] = 32'h0000_0000;
		mem_i.mem[98] = 32'h0000_0a01;
		apb(1'b1, OFS_PTR, 32'h80);
		apb(1'b1, OFS_CTRL, 32'h1);
		waitu(UNIT_SUSP);
		chk(cfg_word, 32'h0000_0a01);
		chk(mem_i.mem[96], cw(3'b010, OP_CFG) | 32'h0000_a000);
		rdc(OFS_STAT, 32'h301);
		chk(n_la, 2);
		results();
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		results();
	end
endmodule : tb_action_command_unit
